/* core/isr_pkg.sv */
// Constants, types and state layout for the instrument status reporting block.
// Assumes one 20 MHz clock and an active-low asynchronous reset.
package isr_pkg;
   localparam int             QDEPTH      = 255;
   localparam int             QAW         = 8;
   localparam logic [QAW-1:0] QMAX        = 8'hff;
   localparam logic [15:0]    CODE_NONE   = 16'h0000;
   localparam logic [15:0]    CODE_CONFL  = 16'hff23;
   localparam int             SB_QUEUE    = 2;
   localparam int             SB_QUES     = 3;
   localparam int             SB_MAV      = 4;
   localparam int             SB_ESB      = 5;
   localparam int             SB_RQS      = 6;
   localparam int             SB_OPER     = 7;
   localparam logic [7:0]     SRE_MASK    = 8'hbc;

   typedef enum logic [1:0] {
      ISR_LOCAL   = 2'b00,
      ISR_REMOTE  = 2'b01,
      ISR_LOCKOUT = 2'b10
   } isr_mode_type;

   typedef struct packed {
      logic [15:0] ptr;
      logic [15:0] ntr;
      logic [15:0] ena;
   } isr_cfg_type;

   typedef struct packed {
      logic [15:0] cond;
      logic [15:0] evt;
   } isr_set_type;

   typedef struct packed {
      logic [QAW-1:0] rd;
      logic [QAW-1:0] wr;
      logic [QAW-1:0] cnt;
      logic [15:0]    rcode;
      logic           rvalid;
      isr_mode_type   mode;
   } isr_top_type;
endpackage : isr_pkg

/* core/isr_regset.sv */
// One SCPI register set: condition, filtered event and enabled summary.
// Assumes condition inputs are synchronous to the clock.
`timescale 1ns/1ps
module isr_regset (
   input  wire logic                 i_core_clk,
   input  wire logic                 i_rst_n,
   input  wire logic [15:0]          i_cond,
   input  wire isr_pkg::isr_cfg_type i_cfg,
   input  wire logic                 i_evt_read,
   input  wire logic                 i_clear,
   output logic [15:0]               o_cond,
   output logic [15:0]               o_evt,
   output logic                      o_summary
);
   isr_pkg::isr_set_type s_q;
   isr_pkg::isr_set_type s_d;
   logic [15:0]          hit;

   always_comb begin
      s_d = s_q;
      s_d.cond = i_cond;
      hit = (i_cond & ~s_q.cond & i_cfg.ptr)
          | (~i_cond & s_q.cond & i_cfg.ntr);
      if (i_evt_read || i_clear) begin
         s_d.evt = hit;
      end else begin
         s_d.evt = s_q.evt | hit;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign o_cond    = s_q.cond;
   assign o_evt     = s_q.evt;
   assign o_summary = |(s_q.evt & i_cfg.ena);

   property p_rise;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_cond[0] && !s_q.cond[0] && i_cfg.ptr[0]) |=> o_evt[0];
   endproperty
   a_rise: assert property (p_rise) else $error("rise not reported");

   property p_fall;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (!i_cond[0] && s_q.cond[0] && i_cfg.ntr[0]) |=> o_evt[0];
   endproperty
   a_fall: assert property (p_fall) else $error("fall not reported");

   property p_sticky;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (o_evt[0] && !i_evt_read && !i_clear) |=> o_evt[0];
   endproperty
   a_sticky: assert property (p_sticky) else $error("event bit lost");

   property p_none;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (!i_cfg.ptr[1] && !i_cfg.ntr[1] && (i_evt_read || i_clear)) |=> !o_evt[1];
   endproperty
   a_none: assert property (p_none) else $error("filtered bit set");
endmodule : isr_regset

/* core/isr_top.sv */
// Status reporting core: error queue, register sets, status byte, panel gating.
// Assumes command decoding is done outside and arrives as one-cycle pulses.
`timescale 1ns/1ps
module isr_top (
   input  wire logic                 i_core_clk,
   input  wire logic                 i_rst_n,
   input  wire logic                 i_err_push,
   input  wire logic [15:0]          i_err_code,
   input  wire logic                 i_settings_conflict,
   input  wire logic                 i_error_queue_read,
   input  wire logic                 i_clear_status,
   input  wire logic [15:0]          i_ques_cond,
   input  wire isr_pkg::isr_cfg_type i_ques_cfg,
   input  wire logic                 i_ques_evt_read,
   input  wire logic [15:0]          i_oper_cond,
   input  wire isr_pkg::isr_cfg_type i_oper_cfg,
   input  wire logic                 i_oper_evt_read,
   input  wire logic [7:0]           i_std_event,
   input  wire logic                 i_msg_avail,
   input  wire logic [7:0]           i_srq_enable,
   input  wire logic                 i_enter_remote,
   input  wire logic                 i_enter_remote_lockout,
   input  wire logic                 i_return_to_panel,
   input  wire logic                 i_panel_key_lock,
   input  wire logic [15:0]          i_keys,
   input  wire logic                 i_local_key,
   input  wire logic                 i_stop_key,
   output logic [15:0]               o_err_code,
   output logic                      o_err_valid,
   output logic                      o_err_empty,
   output logic [isr_pkg::QAW-1:0]   o_err_count,
   output logic [15:0]               o_service_summary_byte,
   output logic                      o_master_summary,
   output logic                      o_srq,
   output logic [15:0]               o_ques_cond,
   output logic [15:0]               o_ques_evt,
   output logic [15:0]               o_oper_cond,
   output logic [15:0]               o_oper_evt,
   output logic [15:0]               o_keys,
   output logic                      o_local_key,
   output logic                      o_stop_key,
   output logic [1:0]                o_mode
);
   isr_pkg::isr_top_type t_q;
   isr_pkg::isr_top_type t_d;
   logic [15:0]          mem_q [isr_pkg::QDEPTH];
   logic                 do_push;
   logic [15:0]          push_code;
   logic                 ques_sum;
   logic                 oper_sum;
   logic [7:0]           sb_low;
   logic                 mss;

   function automatic logic [isr_pkg::QAW-1:0] wrap_inc(input logic [isr_pkg::QAW-1:0] p);
      if (p == isr_pkg::QMAX - 8'h01) begin
         wrap_inc = '0;
      end else begin
         wrap_inc = p + 8'h01;
      end
   endfunction : wrap_inc

   isr_regset u_ques (
      .i_core_clk (i_core_clk),
      .i_rst_n    (i_rst_n),
      .i_cond     (i_ques_cond),
      .i_cfg      (i_ques_cfg),
      .i_evt_read (i_ques_evt_read),
      .i_clear    (i_clear_status),
      .o_cond     (o_ques_cond),
      .o_evt      (o_ques_evt),
      .o_summary  (ques_sum)
   );

   isr_regset u_oper (
      .i_core_clk (i_core_clk),
      .i_rst_n    (i_rst_n),
      .i_cond     (i_oper_cond),
      .i_cfg      (i_oper_cfg),
      .i_evt_read (i_oper_evt_read),
      .i_clear    (i_clear_status),
      .o_cond     (o_oper_cond),
      .o_evt      (o_oper_evt),
      .o_summary  (oper_sum)
   );

   // A conflict from the command path has priority over a generic push.
   always_comb begin
      push_code = i_settings_conflict ? isr_pkg::CODE_CONFL : i_err_code;
      do_push   = (i_settings_conflict || i_err_push) && !i_clear_status;
   end

   always_comb begin
      t_d = t_q;
      t_d.rvalid = 1'b0;
      if (i_clear_status) begin
         t_d.rd  = '0;
         t_d.wr  = '0;
         t_d.cnt = '0;
      end else begin
         if (i_error_queue_read) begin
            t_d.rvalid = 1'b1;
            if (t_q.cnt != '0) begin
               t_d.rcode = mem_q[t_q.rd];
               t_d.rd    = wrap_inc(t_q.rd);
            end else begin
               t_d.rcode = isr_pkg::CODE_NONE;
            end
         end
         if (do_push && t_q.cnt != isr_pkg::QMAX) begin
            t_d.wr = wrap_inc(t_q.wr);
         end
         case ({do_push && t_q.cnt != isr_pkg::QMAX,
                i_error_queue_read && t_q.cnt != '0})
            2'b10:   t_d.cnt = t_q.cnt + 8'h01;
            2'b01:   t_d.cnt = t_q.cnt - 8'h01;
            default: t_d.cnt = t_q.cnt;
         endcase
      end
      if (i_return_to_panel) begin
         t_d.mode = isr_pkg::ISR_LOCAL;
      end else if (i_enter_remote_lockout) begin
         t_d.mode = isr_pkg::ISR_LOCKOUT;
      end else if (i_enter_remote) begin
         t_d.mode = isr_pkg::ISR_REMOTE;
      end else if (i_local_key && t_q.mode == isr_pkg::ISR_REMOTE) begin
         t_d.mode = isr_pkg::ISR_LOCAL;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         t_q <= '{rd: '0, wr: '0, cnt: '0, rcode: '0, rvalid: 1'b0,
                  mode: isr_pkg::ISR_LOCAL};
      end else begin
         t_q <= t_d;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (do_push && t_q.cnt != isr_pkg::QMAX) begin
         mem_q[t_q.wr] <= push_code;
      end
   end

   always_comb begin
      sb_low = 8'h00;
      sb_low[isr_pkg::SB_QUEUE] = (t_q.cnt != '0);
      sb_low[isr_pkg::SB_QUES]  = ques_sum;
      sb_low[isr_pkg::SB_MAV]   = i_msg_avail;
      sb_low[isr_pkg::SB_ESB]   = |i_std_event;
      sb_low[isr_pkg::SB_OPER]  = oper_sum;
      mss = |(sb_low & i_srq_enable & isr_pkg::SRE_MASK);
      sb_low[isr_pkg::SB_RQS]   = mss;
   end

   // Reads of the byte are pure taps, so serial poll and query never disturb it.
   assign o_service_summary_byte = {8'h00, sb_low};
   assign o_master_summary = mss;
   assign o_srq            = mss;
   assign o_err_code       = t_q.rcode;
   assign o_err_valid      = t_q.rvalid;
   assign o_err_empty      = (t_q.cnt == '0);
   assign o_err_count      = t_q.cnt;
   assign o_mode           = t_q.mode;

   always_comb begin
      o_stop_key = i_stop_key;
      if (t_q.mode == isr_pkg::ISR_LOCAL && !i_panel_key_lock) begin
         o_keys      = i_keys;
         o_local_key = i_local_key;
      end else if (t_q.mode == isr_pkg::ISR_REMOTE) begin
         o_keys      = '0;
         o_local_key = i_local_key;
      end else begin
         o_keys      = '0;
         o_local_key = 1'b0;
      end
   end

   property p_empty_read;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_error_queue_read && t_q.cnt == '0 && !i_clear_status)
         |=> (o_err_valid && o_err_code == isr_pkg::CODE_NONE);
   endproperty
   a_empty_read: assert property (p_empty_read) else $error("empty read bad");

   property p_clear;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      i_clear_status |=> o_err_empty;
   endproperty
   a_clear: assert property (p_clear) else $error("queue not cleared");

   property p_full;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (t_q.cnt == isr_pkg::QMAX && !i_error_queue_read && !i_clear_status)
         |=> t_q.cnt == isr_pkg::QMAX;
   endproperty
   a_full: assert property (p_full) else $error("full queue changed");

   property p_qbit;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      o_service_summary_byte[isr_pkg::SB_QUEUE] == !o_err_empty;
   endproperty
   a_qbit: assert property (p_qbit) else $error("queue bit wrong");

   property p_reserved;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      o_service_summary_byte[1:0] == 2'b00 && o_service_summary_byte[15:8] == 8'h00;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bit set");

   property p_srq;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      o_srq == |(o_service_summary_byte[7:0] & i_srq_enable & isr_pkg::SRE_MASK);
   endproperty
   a_srq: assert property (p_srq) else $error("request line wrong");

   property p_lockout;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (o_mode == isr_pkg::ISR_LOCKOUT) |-> (o_keys == '0 && !o_local_key);
   endproperty
   a_lockout: assert property (p_lockout) else $error("key leaked");

   property p_conflict;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_settings_conflict && !i_clear_status && t_q.cnt == '0 && !i_error_queue_read)
         ##1 i_error_queue_read && !i_clear_status |=> o_err_code == isr_pkg::CODE_CONFL;
   endproperty
   a_conflict: assert property (p_conflict) else $error("conflict code wrong");

   property p_push_count;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (do_push && t_q.cnt != isr_pkg::QMAX && !i_error_queue_read)
         |=> o_err_count == $past(o_err_count) + 8'h01;
   endproperty
   a_push_count: assert property (p_push_count) else $error("push not counted");

   property p_pop_count;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_error_queue_read && t_q.cnt != '0 && !do_push && !i_clear_status)
         |=> o_err_count == $past(o_err_count) - 8'h01;
   endproperty
   a_pop_count: assert property (p_pop_count) else $error("pop not counted");

   property p_valid_pulse;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      !i_error_queue_read |=> !o_err_valid;
   endproperty
   a_valid_pulse: assert property (p_valid_pulse) else $error("valid without read");

   property p_code_hold;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      !i_error_queue_read |=> $stable(o_err_code);
   endproperty
   a_code_hold: assert property (p_code_hold) else $error("code changed");

   property p_lock_hold;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (o_mode == isr_pkg::ISR_LOCKOUT && !i_return_to_panel && !i_enter_remote)
         |=> o_mode == isr_pkg::ISR_LOCKOUT;
   endproperty
   a_lock_hold: assert property (p_lock_hold) else $error("lockout left");

   property p_local_key;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (o_mode == isr_pkg::ISR_REMOTE && i_local_key && !i_enter_remote
         && !i_enter_remote_lockout) |=> o_mode == isr_pkg::ISR_LOCAL;
   endproperty
   a_local_key: assert property (p_local_key) else $error("local key ignored");

   property p_remote_keys;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (o_mode == isr_pkg::ISR_REMOTE) |-> (o_keys == '0 && o_local_key == i_local_key);
   endproperty
   a_remote_keys: assert property (p_remote_keys) else $error("remote keys wrong");

   property p_stop;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      o_stop_key == i_stop_key;
   endproperty
   a_stop: assert property (p_stop) else $error("stop switch gated");

   property p_ques_bit;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      o_service_summary_byte[isr_pkg::SB_QUES] == |(o_ques_evt & i_ques_cfg.ena);
   endproperty
   a_ques_bit: assert property (p_ques_bit) else $error("questionable bit wrong");

   property p_oper_bit;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      o_service_summary_byte[isr_pkg::SB_OPER] == |(o_oper_evt & i_oper_cfg.ena);
   endproperty
   a_oper_bit: assert property (p_oper_bit) else $error("operation bit wrong");

   property p_esb;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      o_service_summary_byte[isr_pkg::SB_ESB] == |i_std_event;
   endproperty
   a_esb: assert property (p_esb) else $error("standard event bit wrong");

   property p_mav;
      @(posedge i_core_clk) disable iff (!i_rst_n)
      o_service_summary_byte[isr_pkg::SB_MAV] == i_msg_avail;
   endproperty
   a_mav: assert property (p_mav) else $error("message bit wrong");
endmodule : isr_top

/* testbench/isr_host_model.sv */
// Remote host model: pops one error queue entry on each request.
// Assumes the block answers one cycle after the pop pulse is sampled.
`timescale 1ns/1ps
module isr_host_model (
   input  wire logic        i_core_clk,
   input  wire logic        i_go,
   input  wire logic        i_err_valid,
   input  wire logic [15:0] i_err_code,
   output logic             o_read,
   output logic [15:0]      o_code,
   output logic             o_done
);
   initial begin
      o_read = 1'b0;
      o_code = 16'h0000;
      o_done = 1'b0;
      forever begin
         @(posedge i_core_clk);
         if (i_go) begin
            o_done <= 1'b0;
            o_read <= 1'b1;
            @(posedge i_core_clk);
            o_read <= 1'b0;
            @(posedge i_core_clk);
            o_code <= i_err_valid ? i_err_code : 16'hbad0;
            o_done <= 1'b1;
         end
      end
   end
endmodule : isr_host_model

/* testbench/isr_top_tb.sv */
// Self-checking testbench for the status reporting core.
// Assumes a 20 MHz clock and an active-low asynchronous reset.
`timescale 1ns/1ps
module isr_top_tb;
   logic clk, rst_n, push, conf, clr, qrd, qer, oer, msg, lock, rem, rwl, rtp, lk, sk, go;
   logic ev, emp, ms, srq, olk, osk, hdone;
   logic [15:0] code, qc, oc, keys, ecode, sb, qco, qev, oco, oev, okeys, hcode;
   logic [7:0]  std, sre, ecnt;
   logic [1:0]  mode;
   isr_pkg::isr_cfg_type qcfg, ocfg;
   int          failures, compares;

   isr_top dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_err_push(push), .i_err_code(code),
      .i_settings_conflict(conf), .i_error_queue_read(qrd), .i_clear_status(clr),
      .i_ques_cond(qc), .i_ques_cfg(qcfg), .i_ques_evt_read(qer), .i_oper_cond(oc),
      .i_oper_cfg(ocfg), .i_oper_evt_read(oer), .i_std_event(std), .i_msg_avail(msg),
      .i_srq_enable(sre), .i_enter_remote(rem), .i_enter_remote_lockout(rwl),
      .i_return_to_panel(rtp), .i_panel_key_lock(lock), .i_keys(keys), .i_local_key(lk),
      .i_stop_key(sk), .o_err_code(ecode), .o_err_valid(ev), .o_err_empty(emp),
      .o_err_count(ecnt), .o_service_summary_byte(sb), .o_master_summary(ms), .o_srq(srq),
      .o_ques_cond(qco), .o_ques_evt(qev), .o_oper_cond(oco), .o_oper_evt(oev),
      .o_keys(okeys), .o_local_key(olk), .o_stop_key(osk), .o_mode(mode));

   isr_host_model host (.i_core_clk(clk), .i_go(go), .i_err_valid(ev), .i_err_code(ecode),
      .o_read(qrd), .o_code(hcode), .o_done(hdone));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      compares++;
      if (g !== e) begin
         failures++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic complete_run();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : complete_run

   task automatic pop(input logic [15:0] e, input string nm);
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      conf <= 1'b0;
      repeat (3) @(posedge clk);
      chk(nm, e, hcode);
   endtask : pop

   task automatic pulse_clr();
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      @(negedge clk);
   endtask : pulse_clr

   task automatic t_queue();
      push <= 1'b1;
      for (int i = 1; i <= 3; i++) begin
         code <= 16'(i);
         @(posedge clk);
      end
      push <= 1'b0;
      conf <= 1'b1;
      @(posedge clk);
      conf <= 1'b0;
      @(negedge clk);
      chk("count", 16'h0004, {8'h00, ecnt});
      chk("qbit", 16'h0004, sb & 16'h0004);
      chk("nonempty", 16'h0000, {15'h0000, emp});
      @(posedge clk);
      for (int i = 1; i <= 3; i++) pop(16'(i), "order");
      pop(16'hff23, "conflict");
      pop(16'h0000, "empty");
      chk("qbit0", 16'h0000, sb & 16'h0004);
      chk("empty flag", 16'h0001, {15'h0000, emp});
      $display("queue test done");
   endtask : t_queue

   task automatic t_full();
      push <= 1'b1;
      for (int i = 0; i < 260; i++) begin
         code <= 16'(i + 256);
         @(posedge clk);
      end
      push <= 1'b0;
      repeat (2) @(posedge clk);
      chk("full", 16'h00ff, {8'h00, ecnt});
      pop(16'h0100, "oldest");
      pulse_clr();
      chk("cleared", 16'h0000, {8'h00, ecnt});
      @(posedge clk);
      pop(16'h0000, "after clear");
      conf <= 1'b1;
      pop(16'hff23, "conflict read");
      $display("full test done");
   endtask : t_full

   task automatic t_filter();
      qcfg <= '{ptr: 16'h0005, ntr: 16'h0006, ena: 16'h0001};
      ocfg <= '{ptr: 16'h8000, ntr: 16'h0000, ena: 16'h8000};
      @(posedge clk);
      qc <= 16'h000f;
      oc <= 16'h8000;
      repeat (3) @(posedge clk);
      chk("qcond", 16'h000f, qco);
      chk("rise", 16'h0005, qev);
      chk("orise", 16'h8000, oev);
      chk("ocond", 16'h8000, oco);
      chk("sums", 16'h0088, sb & 16'h0088);
      qc <= 16'h0000;
      repeat (3) @(posedge clk);
      chk("fall", 16'h0007, qev);
      chk("qcond0", 16'h0000, qco);
      qer <= 1'b1;
      @(posedge clk);
      qer <= 1'b0;
      @(negedge clk);
      chk("read", 16'h0000, qev);
      chk("qsum0", 16'h0000, sb & 16'h0008);
      chk("ostay", 16'h8000, oev);
      @(posedge clk);
      pulse_clr();
      chk("oclr", 16'h0000, oev);
      @(posedge clk);
      oc <= 16'h0000;
      @(posedge clk);
      oc <= 16'h8000;
      repeat (2) @(posedge clk);
      chk("orise2", 16'h8000, oev);
      oer <= 1'b1;
      @(posedge clk);
      oer <= 1'b0;
      @(negedge clk);
      chk("oread", 16'h0000, oev);
      $display("filter test done");
   endtask : t_filter

   task automatic t_sbyte();
      std <= 8'h01;
      msg <= 1'b1;
      sre <= 8'h40;
      @(posedge clk);
      @(negedge clk);
      chk("byte", 16'h0030, sb);
      chk("srq off", 16'h0000, {14'h0000, ms, srq});
      @(posedge clk);
      sre <= 8'h20;
      @(negedge clk);
      chk("rqs", 16'h0070, sb);
      chk("srq on", 16'h0003, {14'h0000, ms, srq});
      repeat (4) @(posedge clk);
      chk("stable", 16'h0070, sb);
      $display("status byte test done");
   endtask : t_sbyte

   task automatic t_panel();
      keys <= 16'hffff;
      sk <= 1'b1;
      rem <= 1'b1;
      @(posedge clk);
      rem <= 1'b0;
      @(negedge clk);
      chk("remote", 16'h0001, {14'h0000, mode});
      chk("rkeys", 16'h0000, okeys);
      chk("rstop", 16'h0001, {15'h0000, osk});
      @(posedge clk);
      lk <= 1'b1;
      @(negedge clk);
      chk("rlocal", 16'h0001, {15'h0000, olk});
      @(posedge clk);
      @(negedge clk);
      chk("back", 16'h0000, {14'h0000, mode});
      @(posedge clk);
      rwl <= 1'b1;
      @(posedge clk);
      rwl <= 1'b0;
      @(negedge clk);
      chk("lockout", 16'h0002, {14'h0000, mode});
      chk("llocal", 16'h0000, {15'h0000, olk});
      chk("lkeys", 16'h0000, okeys);
      chk("lstop", 16'h0001, {15'h0000, osk});
      @(posedge clk);
      rtp <= 1'b1;
      @(posedge clk);
      rtp <= 1'b0;
      @(negedge clk);
      chk("panel", 16'hffff, okeys);
      $display("panel test done");
   endtask : t_panel

   initial begin
      {push, conf, clr, qer, oer, msg, lock, rem, rwl, rtp, lk, sk, go} = '0;
      {code, qc, oc, keys, std, sre} = '0;
      qcfg = '0;
      ocfg = '0;
      rst_n = 1'b0;
      failures = 0;
      compares = 0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_queue();
      t_full();
      t_filter();
      t_sbyte();
      @(posedge clk);
      t_panel();
      complete_run();
   end

   initial begin
      repeat (8000) @(posedge clk);
      failures++;
      complete_run();
   end
endmodule : isr_top_tb
